// >>> frpwc_timer.sv
// Purpose: free-running and pulse width capture timer channel with APB registers
// Assumes: pclk 40 MHz, presetn asynchronous active low, APB master per protocol
// Notes: count clock is a one-cycle enable from a divider or from capture_input_0
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps

// Summary of operation
// - width mode: counting starts from zero on enable
// - width mode edge: capture, clear counter, irq
// - after FFFFH next tick: wrap irq, zero; a width-mode capture on that tick wins and drops the wrap irq
// - wrap sets sticky flag until software clears
// - zero write to bit or byte clears
// - set beats a coinciding clear
// - external clock on input 0, measure input 1
// - free mode compares each register independently while its select bit is clear
// - free mode never clears counter, only wraps
// - select bits choose capture or compare
// - free capture latches counter, counter untouched
// - compare match raises irq, toggles output
module frpwc_timer
	import frpwc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              capture_input_0,
	input  wire logic              capture_input_1,
	output logic      [1:0]        match_or_capture_irq,
	output logic                   wrap_irq,
	output logic      [1:0]        timer_output_pin
);
	frpwc_ctl_s   control_reg_0;
	frpwc_ctl_s   next_control_reg_0;
	frpwc_edge_s  edge_select_reg;
	frpwc_edge_s  next_edge_select_reg;
	logic [1:0]   capture_select;
	logic [1:0]   next_capture_select;
	logic         wrap_flag;
	logic         next_wrap_flag;
	logic [15:0]  capture_compare_reg [2];
	logic [15:0]  next_ccr [2];
	logic [15:0]  counter;
	logic [15:0]  next_counter;
	logic [7:0]   div_cnt;
	logic [7:0]   next_div_cnt;
	logic [1:0]   cap_pend;
	logic [1:0]   next_cap_pend;
	logic         ce_q;
	logic [1:0]   next_irq;
	logic         next_wrap_irq;
	logic [1:0]   next_out;
	logic [31:0]  next_prdata;
	logic         next_pready;
	logic         next_pslverr;
	logic         rise0;
	logic         fall0;
	logic         rise1;
	logic         fall1;
	logic [1:0]   hit;
	logic         tick;
	logic [7:0]   div_mask;
	logic         wr;
	logic         rd_phase;
	logic [7:0]   addr;

	frpwc_edge_sync u_sync0 (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (capture_input_0),
		.rise    (rise0),
		.fall    (fall0)
	);

	frpwc_edge_sync u_sync1 (
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (capture_input_1),
		.rise    (rise1),
		.fall    (fall1)
	);

	function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
		edge_hit = (sel[0] & r) | (sel[1] & f);
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == OFF_CTL) || (a == OFF_OPT) || (a == OFF_EDGE) || (a == OFF_CCR0)
			|| (a == OFF_CCR1) || (a == OFF_CNT) || (a == OFF_FCLR);
	endfunction

	assign addr     = 8'(paddr);
	assign wr       = psel & penable & pready & pwrite;
	assign rd_phase = psel & penable & ~pready;
	assign div_mask = 8'((DIV_ONE << control_reg_0.clk_sel) - DIV_ONE);
	// external clock takes input 0; its edge selection is then ignored
	assign tick = control_reg_0.ext_clk ? rise0 : ((div_cnt & div_mask) == div_mask);
	assign hit[0] = ~control_reg_0.ext_clk
		& edge_hit({edge_select_reg.input0_edge_sel_hi, edge_select_reg.input0_edge_sel_lo},
			rise0, fall0);
	assign hit[1] = edge_hit(edge_select_reg.input1_edge_sel, rise1, fall1);

	// apb slave: one wait state, registered answer
	always_comb begin
		next_pready  = rd_phase;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (rd_phase) begin
			next_pslverr = ~is_mapped(addr);
			if (pwrite) begin
				next_prdata = prdata;
			end else if (addr == OFF_CTL) begin
				next_prdata = {24'h000000, control_reg_0};
			end else if (addr == OFF_OPT) begin
				next_prdata = {26'h0000000, capture_select, 3'h0, wrap_flag};
			end else if (addr == OFF_EDGE) begin
				next_prdata = {28'h0000000, edge_select_reg};
			end else if (addr == OFF_CCR0) begin
				next_prdata = {16'h0000, capture_compare_reg[0]};
			end else if (addr == OFF_CCR1) begin
				next_prdata = {16'h0000, capture_compare_reg[1]};
			end else if (addr == OFF_CNT) begin
				next_prdata = {16'h0000, counter};
			end else begin
				next_prdata = 32'h00000000;
			end
		end
	end

	// configuration and flag
	always_comb begin
		next_control_reg_0   = control_reg_0;
		next_edge_select_reg = edge_select_reg;
		next_capture_select  = capture_select;
		next_wrap_flag       = wrap_flag;
		if (wr && addr == OFF_CTL) begin
			next_control_reg_0 = frpwc_ctl_s'(pwdata[7:0]);
		end
		if (wr && addr == OFF_EDGE) begin
			next_edge_select_reg = frpwc_edge_s'(pwdata[3:0]);
		end
		if (wr && addr == OFF_OPT) begin
			next_capture_select = {pwdata[OPT_CCS1], pwdata[OPT_CCS0]};
			if (!pwdata[OPT_FLAG]) begin
				next_wrap_flag = 1'b0;
			end
		end
		if (wr && addr == OFF_FCLR && !pwdata[FCLR_BIT]) begin
			next_wrap_flag = 1'b0;
		end
		if (next_wrap_irq) begin
			next_wrap_flag = 1'b1;
		end
	end

	// counter, capture and compare
	always_comb begin
		next_div_cnt  = control_reg_0.count_enable_bit ? 8'(div_cnt + DIV_ONE) : 8'h00;
		next_counter  = counter;
		next_ccr      = capture_compare_reg;
		next_irq      = 2'b00;
		next_wrap_irq = 1'b0;
		next_out      = timer_output_pin;
		next_cap_pend = cap_pend | hit;
		if (wr && addr == OFF_CCR0) begin
			next_ccr[0] = 16'(pwdata);
		end
		if (wr && addr == OFF_CCR1) begin
			next_ccr[1] = 16'(pwdata);
		end
		if (!control_reg_0.count_enable_bit) begin
			next_counter  = CNT_ZERO;
			next_cap_pend = 2'b00;
		end else begin
			if (!ce_q && control_reg_0.mode_select_field == MODE_FREE) begin
				next_out = ~timer_output_pin;
			end
			if (tick) begin
				next_cap_pend = hit;
				if (counter == CNT_MAX) begin
					next_counter  = CNT_ZERO;
					next_wrap_irq = 1'b1;
				end else begin
					next_counter = 16'(counter + CNT_ONE);
				end
				if (control_reg_0.mode_select_field == MODE_PWM) begin
					for (int m = 0; m < 2; m++) begin
						if (cap_pend[m]) begin
							next_ccr[m]   = counter;
							next_irq[m]   = 1'b1;
							next_counter  = CNT_ZERO;
							next_wrap_irq = 1'b0;
						end
					end
				end else if (control_reg_0.mode_select_field == MODE_FREE) begin
					for (int m = 0; m < 2; m++) begin
						if (capture_select[m]) begin
							if (cap_pend[m]) begin
								next_ccr[m] = counter;
								next_irq[m] = 1'b1;
							end
						end else if (counter == capture_compare_reg[m]) begin
							next_irq[m] = 1'b1;
							next_out[m] = ~next_out[m];
						end
					end
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata                 <= 32'h00000000;
			pready                 <= 1'b0;
			pslverr                <= 1'b0;
			control_reg_0          <= frpwc_ctl_s'(CTL_RESET);
			edge_select_reg        <= frpwc_edge_s'(EDGE_RESET);
			capture_select         <= 2'b00;
			wrap_flag              <= 1'b0;
			capture_compare_reg[0] <= CNT_ZERO;
			capture_compare_reg[1] <= CNT_ZERO;
			counter                <= CNT_ZERO;
			div_cnt                <= 8'h00;
			cap_pend               <= 2'b00;
			ce_q                   <= 1'b0;
			match_or_capture_irq   <= 2'b00;
			wrap_irq               <= 1'b0;
			timer_output_pin       <= 2'b00;
		end else begin
			prdata                 <= next_prdata;
			pready                 <= next_pready;
			pslverr                <= next_pslverr;
			control_reg_0          <= next_control_reg_0;
			edge_select_reg        <= next_edge_select_reg;
			capture_select         <= next_capture_select;
			wrap_flag              <= next_wrap_flag;
			capture_compare_reg[0] <= next_ccr[0];
			capture_compare_reg[1] <= next_ccr[1];
			counter                <= next_counter;
			div_cnt                <= next_div_cnt;
			cap_pend               <= next_cap_pend;
			ce_q                   <= control_reg_0.count_enable_bit;
			match_or_capture_irq   <= next_irq;
			wrap_irq               <= next_wrap_irq;
			timer_output_pin       <= next_out;
		end
	end
endmodule

// >>> frpwc_pkg.sv
// Purpose: shared constants and types, plus the capture pin synchroniser
// Assumes: one clock pclk, asynchronous active-low reset presetn
// Notes: register offsets are byte addresses on an APB bus with 32-bit data
package frpwc_pkg;
	localparam logic [2:0]  MODE_FREE   = 3'h5;
	localparam logic [2:0]  MODE_PWM    = 3'h6;
	localparam logic [7:0]  OFF_CTL     = 8'h00;
	localparam logic [7:0]  OFF_OPT     = 8'h04;
	localparam logic [7:0]  OFF_EDGE    = 8'h08;
	localparam logic [7:0]  OFF_CCR0    = 8'h0C;
	localparam logic [7:0]  OFF_CCR1    = 8'h10;
	localparam logic [7:0]  OFF_CNT     = 8'h14;
	localparam logic [7:0]  OFF_FCLR    = 8'h18;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [15:0] CNT_ONE     = 16'h0001;
	localparam logic [7:0]  DIV_ONE     = 8'h01;
	localparam logic [7:0]  CTL_RESET   = 8'h00;
	localparam logic [3:0]  EDGE_RESET  = 4'h0;
	localparam logic [1:0]  EDGE_NONE   = 2'h0;
	localparam int          OPT_FLAG    = 0;
	localparam int          OPT_CCS0    = 4;
	localparam int          OPT_CCS1    = 5;
	localparam int          FCLR_BIT    = 0;

	typedef struct packed {
		logic       count_enable_bit;
		logic [2:0] clk_sel;
		logic       ext_clk;
		logic [2:0] mode_select_field;
	} frpwc_ctl_s;

	typedef struct packed {
		logic [1:0] input1_edge_sel;
		logic       input0_edge_sel_hi;
		logic       input0_edge_sel_lo;
	} frpwc_edge_s;
endpackage

`timescale 1ns/1ps
module frpwc_edge_sync
	import frpwc_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	logic s1;
	logic s2;
	logic s3;
	logic level;
	logic next_level;
	logic next_rise;
	logic next_fall;

	// level changes once second and third stages agree
	always_comb begin
		next_level = level;
		next_rise  = 1'b0;
		next_fall  = 1'b0;
		if (s2 == s3) begin
			next_level = s3;
			next_rise  = s3 & ~level;
			next_fall  = ~s3 & level;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1    <= 1'b0;
			s2    <= 1'b0;
			s3    <= 1'b0;
			level <= 1'b0;
			rise  <= 1'b0;
			fall  <= 1'b0;
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= next_level;
			rise  <= next_rise;
			fall  <= next_fall;
		end
	end
endmodule

// >>> frpwc_timer_sva.sv
// Purpose: port checker for frpwc_timer
// Assumes: single pclk domain, presetn async low
// Notes: watches only what the timer drives
`timescale 1ns/1ps
module frpwc_timer_sva
	import frpwc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              capture_input_0,
	input wire logic              capture_input_1,
	input wire logic [1:0]        match_or_capture_irq,
	input wire logic              wrap_irq,
	input wire logic [1:0]        timer_output_pin
);
	default clocking dcb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_WRAP_PULSE: assert property (wrap_irq |=> !wrap_irq)
		else $error("wrap pulse too long");
	AST_IRQ0_PULSE: assert property (match_or_capture_irq[0] |=> !match_or_capture_irq[0])
		else $error("irq0 pulse too long");
	AST_IRQ1_PULSE: assert property (match_or_capture_irq[1] |=> !match_or_capture_irq[1])
		else $error("irq1 pulse too long");
	AST_RESET_QUIET: assert property ($rose(presetn) |-> !wrap_irq && match_or_capture_irq == 2'h0
		&& timer_output_pin == 2'h0 && !pready)
		else $error("outputs busy after reset");
	AST_PREADY_ANSWER: assert property ($rose(penable) && psel |=> pready)
		else $error("no answer in second access cycle");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("pready outside access");
	AST_SLVERR_READY: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_PRDATA_HOLD: assert property ($changed(prdata) |-> pready && !pwrite)
		else $error("read data moved between reads");
	AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read data not zero");
endmodule

// >>> frpwc_pulse_src.sv
// Purpose: pulse source model on the two capture pins
// Assumes: levels requested by the bench
// Notes: pins idle low; pin 0 may act as external count clock
`timescale 1ns/1ps
module frpwc_pulse_src (
	input  wire logic       pclk,
	input  wire logic [1:0] want,
	output logic            capture_input_0 = 1'b0,
	output logic            capture_input_1 = 1'b0
);
	// pin 0 idle or count clock, width measured on pin 1
	always @(posedge pclk) begin
		capture_input_0 <= want[0];
		capture_input_1 <= want[1];
	end
endmodule

// >>> free_run_and_pulse_width_capture_test.sv
// Purpose: self-checking bench for frpwc_timer
// Assumes: tick every pclk or on pin 0 rise, edges measured on pin 1
// Notes: one full wrap, about 66k cycles
`timescale 1ns/1ps
module free_run_and_pulse_width_capture_test;
	import frpwc_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cin0;
	logic        cin1;
	logic [1:0]  irq;
	logic        wrap_irq;
	logic [1:0]  top;
	logic [1:0]  want;
	logic [2:0]  ev;
	int          err_count = 0;
	int          cmp_count = 0;
	assign ev = {wrap_irq, irq};
	frpwc_pulse_src i_src (.pclk(pclk), .want(want), .capture_input_0(cin0),
		.capture_input_1(cin1));
	frpwc_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_input_0(cin0), .capture_input_1(cin1),
		.match_or_capture_irq(irq), .wrap_irq(wrap_irq), .timer_output_pin(top));
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
		cmp_count++;
		if (g !== x) begin
			err_count++;
			$display("CHECK FAILED %0t %s got %h", $time, m, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(32'(n < 20), 1, "no pready");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
		chk(32'(e), 0, "write refused");
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	task automatic wait_ev(input int i, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (ev[i] !== 1'b1 && n < lim);
		chk(32'(n < lim), 1, "event missing");
	endtask
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		for (int i = 0; i < 7; i++) begin
			rd(8'(4 * i), q);
			chk(q, 0, "reset value");
		end
		apb(1'b0, 8'h1C, 32'h0, q, e);
		chk(32'(e), 1, "unmapped not refused");
	endtask
	task automatic t_free_compare();
		logic [31:0] q;
		wr(OFF_CCR0, 32'h40);
		wr(OFF_CCR1, 32'h80);
		wr(OFF_CTL, {24'h0, 1'b1, 4'h0, MODE_FREE});
		wait_ev(0, 200);
		@(posedge pclk);
		chk(32'(top), 32'h2, "pin 0 not toggled");
		wait_ev(1, 200);
		@(posedge pclk);
		chk(32'(top), 32'h0, "pin 1 not toggled");
		rd(OFF_CNT, q);
		chk(32'(q > 32'h80), 1, "counter cleared by match");
	endtask
	task automatic t_wrap();
		logic [31:0] q;
		wait_ev(2, 70000);
		rd(OFF_CNT, q);
		chk(32'(q < 32'h14), 1, "no wrap to zero");
		rd(OFF_OPT, q);
		chk(q, 32'h1, "flag not set");
		wr(OFF_FCLR, 32'h1);
		rd(OFF_OPT, q);
		chk(q, 32'h1, "flag lost");
		wr(OFF_OPT, 32'h1);
		rd(OFF_OPT, q);
		chk(q, 32'h1, "bit 0 set cleared flag");
		wr(OFF_OPT, 32'h0);
		rd(OFF_OPT, q);
		chk(q, 32'h0, "byte write kept flag");
	endtask
	task automatic t_free_capture();
		logic [31:0] v;
		logic [31:0] c;
		wr(OFF_OPT, 32'h20);
		wr(OFF_EDGE, 32'h4);
		want <= 2'b10;
		wait_ev(1, 50);
		rd(OFF_CCR1, v);
		rd(OFF_CNT, c);
		chk(32'(c > v && v != 32'h80), 1, "capture wrong");
		want <= 2'b00;
	endtask
	task automatic t_pulse();
		logic [31:0] q;
		wr(OFF_CTL, 32'h0);
		rd(OFF_CNT, q);
		chk(q, 0, "stopped counter not zero");
		wr(OFF_CTL, {24'h0, 1'b1, 4'h0, MODE_PWM});
		repeat (50) @(posedge pclk);
		want <= 2'b10;
		wait_ev(1, 50);
		rd(OFF_CCR1, q);
		chk(32'(q >= 32'd45 && q <= 32'd75), 1, "width wrong");
		rd(OFF_CNT, q);
		chk(32'(q < 32'd20), 1, "counter not cleared");
	endtask
	task automatic t_ext_clock();
		logic [31:0] q;
		want <= 2'b00;
		wr(OFF_CTL, 32'h0);
		wr(OFF_CTL, {24'h0, 1'b1, 3'h0, 1'b1, MODE_PWM});
		for (int i = 0; i < 5; i++) begin
			want <= 2'b01;
			repeat (8) @(posedge pclk);
			want <= 2'b00;
			repeat (8) @(posedge pclk);
		end
		want <= 2'b10;
		repeat (8) @(posedge pclk);
		want <= 2'b11;
		wait_ev(1, 50);
		rd(OFF_CCR1, q);
		chk(q, 32'h5, "external ticks miscounted");
		want <= 2'b00;
	endtask
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	initial begin
		#2000000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		want = 2'b00;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_free_compare();
		t_wrap();
		t_free_capture();
		t_pulse();
		t_ext_clock();
		tally_and_finish();
	end
endmodule
bind frpwc_timer frpwc_timer_sva #(.ADDR_W(ADDR_W)) i_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_input_0(capture_input_0),
	.capture_input_1(capture_input_1), .match_or_capture_irq(match_or_capture_irq),
	.wrap_irq(wrap_irq), .timer_output_pin(timer_output_pin));
